// [core/unsigned_simd_exec.sv]
// execute block for unsigned packed halving adds, exchange add/subtract,
// unsigned field extract, unsigned divide and the permanently undefined op
// assumes a combinational register file read and a fetch stage that holds
// the word until o_ready; one instruction in flight at a time
//
// Overview of operation
// - exchange op: swap, add, subtract, set carries
// - packed ops undefined without signal-processing extension
// - register 13 or 15 flags unpredictable
// - field extract needs main extension
// - lsb from joined immediates, top adds width minus one
// - in range: write zero-extended field
// - top beyond 31: raise undefined here
// - lsb 0-31, width carried minus one
// - permanent undefined raises undefined exception
// - permanent undefined payload is ignored
// - divide 32-bit unsigned, quotient to destination
// - divide leaves condition flags alone
// - halving halfword add, two lanes
// - halving byte add, four lanes
// - halving add-subtract with exchange
// - halving subtract-add with exchange
// - 17-bit halfword lanes keep bits 16 to 1, 9-bit byte lanes keep bits 8 to 1
`timescale 1ns/100ps

module unsigned_simd_exec (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_sys_rst,
  // instruction issue
  input  wire logic        i_instr_valid,
  input  wire logic [31:0] i_instr,
  input  wire logic        i_instr_short,
  input  wire logic        i_cond_pass,
  input  wire logic        i_dsp_present,
  input  wire logic        i_main_present,
  input  wire logic        i_div_zero_trap_en,
  output logic             o_ready,
  // register file read
  output logic [3:0]       o_first_source_index,
  output logic [3:0]       o_second_source_index,
  input  wire logic [31:0] i_first_source_data,
  input  wire logic [31:0] i_second_source_data,
  // register and flag write
  output logic             o_reg_wr_en,
  output logic [3:0]       o_reg_wr_index,
  output logic [31:0]      o_reg_wr_data,
  output logic             o_lane_carry_flags_wr_en,
  output logic [3:0]       o_lane_carry_flags,
  // outcome
  output logic             o_done,
  output logic             o_undef_exc,
  output logic             o_unpredictable,
  output logic             o_div_zero_fault
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // register 13 or 15 in a register field
  function automatic logic reg_forbidden(input logic [3:0] idx);
    reg_forbidden = (idx == usimd_pkg::REG_STACK) || (idx == usimd_pkg::REG_COUNTER);
  endfunction

  // ----------------------------------------------------------------
  // field split
  // ----------------------------------------------------------------
  logic [15:0] hw_first;
  logic [15:0] hw_second;
  logic [11:0] opc_hi;
  logic [3:0]  top_nib;
  logic [3:0]  sub_op;
  logic [3:0]  dest_field;
  logic [3:0]  first_source_field;
  logic [3:0]  second_source_field;
  logic [2:0]  lsb_high_bits;
  logic [1:0]  lsb_low_bits;
  logic [4:0]  width_minus_one_field;

  assign hw_first              = i_instr[31:16];
  assign hw_second             = i_instr[15:0];
  assign opc_hi                = hw_first[15:usimd_pkg::OPC_HI_LSB];
  assign top_nib               = hw_second[15:usimd_pkg::NIB_HI_LSB];
  assign sub_op                = hw_second[usimd_pkg::SUBOP_LSB +: 4];
  assign dest_field            = hw_second[usimd_pkg::RD_LSB +: 4];
  assign first_source_field    = hw_first[3:0];
  assign second_source_field   = hw_second[3:0];
  assign lsb_high_bits         = hw_second[usimd_pkg::LSB_HIGH_POS +: 3];
  assign lsb_low_bits          = hw_second[usimd_pkg::LSB_LOW_POS +: 2];
  assign width_minus_one_field = hw_second[4:0];
  assign o_first_source_index  = first_source_field;
  assign o_second_source_index = second_source_field;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic long_form;
  logic dsp_row;
  logic add_sub_exchange_op;
  logic halving_add_sub_exchange_op;
  logic halving_sub_add_exchange_op;
  logic halving_add_halfwords_op;
  logic halving_add_bytes_op;
  logic unsigned_field_extract_op;
  logic unsigned_divide_op;
  logic permanent_undefined_op;
  logic packed_op;
  logic three_reg_op;
  logic recognized;

  // the payload fields of the undefined op are never looked at
  assign long_form                   = !i_instr_short;
  assign dsp_row                     = long_form && (top_nib == usimd_pkg::NIB_ONES);
  assign add_sub_exchange_op         = dsp_row && opc_hi == usimd_pkg::OPC_ASX && sub_op == usimd_pkg::SUB_PLAIN;
  assign halving_add_sub_exchange_op = dsp_row && opc_hi == usimd_pkg::OPC_ASX && sub_op == usimd_pkg::SUB_HALVING;
  assign halving_sub_add_exchange_op = dsp_row && opc_hi == usimd_pkg::OPC_HSAX && sub_op == usimd_pkg::SUB_HALVING;
  assign halving_add_halfwords_op    = dsp_row && opc_hi == usimd_pkg::OPC_HADD16 && sub_op == usimd_pkg::SUB_HALVING;
  assign halving_add_bytes_op        = dsp_row && opc_hi == usimd_pkg::OPC_HADD8 && sub_op == usimd_pkg::SUB_HALVING;
  assign unsigned_field_extract_op   = long_form && hw_first[15:11] == usimd_pkg::OPC_FIELD_A
                                       && hw_first[9:4] == usimd_pkg::OPC_FIELD_B
                                       && !hw_second[usimd_pkg::XTR_ZERO_POS];
  assign unsigned_divide_op          = long_form && opc_hi == usimd_pkg::OPC_DIVIDE && sub_op == usimd_pkg::SUB_DIVIDE;
  assign permanent_undefined_op      = (long_form && opc_hi == usimd_pkg::OPC_UNDEF_L
                                        && top_nib == usimd_pkg::NIB_UNDEF_L)
                                       || (i_instr_short
                                        && hw_second[usimd_pkg::SHORT_OP_LSB +: 8] == usimd_pkg::OPC_UNDEF_S);
  assign packed_op                   = add_sub_exchange_op | halving_add_sub_exchange_op
                                       | halving_sub_add_exchange_op | halving_add_halfwords_op
                                       | halving_add_bytes_op;
  assign three_reg_op                = packed_op | unsigned_divide_op;
  assign recognized                  = three_reg_op | unsigned_field_extract_op | permanent_undefined_op;

  // ----------------------------------------------------------------
  // field extract positions
  // ----------------------------------------------------------------
  logic [4:0]  field_lsb;
  logic [5:0]  field_top;
  logic        field_over;
  logic [31:0] field_mask;
  logic [31:0] field_result;

  assign field_lsb    = {lsb_high_bits, lsb_low_bits};
  assign field_top    = {1'b0, field_lsb} + {1'b0, width_minus_one_field};
  assign field_over   = field_top[5];
  assign field_mask   = 32'hFFFF_FFFF >> (usimd_pkg::FIELD_TOP - width_minus_one_field);
  assign field_result = (i_first_source_data >> field_lsb) & field_mask;

  // ----------------------------------------------------------------
  // halfword lanes, 17 bits wide
  // ----------------------------------------------------------------
  logic [15:0] n_lo;
  logic [15:0] n_hi;
  logic [15:0] m_lo;
  logic [15:0] m_hi;
  logic [16:0] xsum_hi;
  logic [16:0] xdiff_lo;
  logic [16:0] xsum_lo;
  logic [16:0] xdiff_hi;
  logic [16:0] psum_lo;
  logic [16:0] psum_hi;

  assign n_lo     = i_first_source_data[15:0];
  assign n_hi     = i_first_source_data[31:16];
  assign m_lo     = i_second_source_data[15:0];
  assign m_hi     = i_second_source_data[31:16];
  assign xsum_hi  = {1'b0, n_hi} + {1'b0, m_lo};
  assign xdiff_lo = {1'b0, n_lo} - {1'b0, m_hi};
  assign xsum_lo  = {1'b0, n_lo} + {1'b0, m_hi};
  assign xdiff_hi = {1'b0, n_hi} - {1'b0, m_lo};
  assign psum_lo  = {1'b0, n_lo} + {1'b0, m_lo};
  assign psum_hi  = {1'b0, n_hi} + {1'b0, m_hi};

  logic [31:0] byte_halved;
  genvar       g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_byte_lane
      logic [8:0] lane_sum;
      assign lane_sum = {1'b0, i_first_source_data[g*8 +: 8]} + {1'b0, i_second_source_data[g*8 +: 8]};
      assign byte_halved[g*8 +: 8] = lane_sum[8:1];
    end
  endgenerate

  // ----------------------------------------------------------------
  // result select
  // ----------------------------------------------------------------
  logic [31:0] alu_result;
  logic [3:0]  carry_flags;

  assign alu_result = add_sub_exchange_op         ? {xsum_hi[15:0], xdiff_lo[15:0]} :
                      halving_add_sub_exchange_op ? {xsum_hi[16:1], xdiff_lo[16:1]} :
                      halving_sub_add_exchange_op ? {xdiff_hi[16:1], xsum_lo[16:1]} :
                      halving_add_halfwords_op    ? {psum_hi[16:1], psum_lo[16:1]} :
                      halving_add_bytes_op        ? byte_halved : field_result;
  assign carry_flags = {{2{~xdiff_lo[16]}}, {2{xsum_hi[16]}}};

  // ----------------------------------------------------------------
  // issue outcome
  // ----------------------------------------------------------------
  usimd_pkg::exec_state_t state_q;
  usimd_pkg::exec_state_t state_d;
  logic        issue;
  logic        undef_now;
  logic        unpred_now;
  logic        exec_ok;
  logic        divisor_zero;
  logic        div_start;
  logic        div_zero_write;
  logic        div_zero_trap;
  logic        imm_write;
  logic        flags_write;

  assign o_ready      = (state_q == usimd_pkg::ST_IDLE);
  assign issue        = i_instr_valid && o_ready;
  assign undef_now    = (packed_op && !i_dsp_present)
                        || (unsigned_field_extract_op && (!i_main_present || field_over))
                        || permanent_undefined_op;
  assign unpred_now   = (three_reg_op && (reg_forbidden(dest_field) || reg_forbidden(first_source_field)
                                          || reg_forbidden(second_source_field)))
                        || (unsigned_field_extract_op && (reg_forbidden(dest_field)
                                                          || reg_forbidden(first_source_field)));
  assign exec_ok        = issue && i_cond_pass && !undef_now;
  assign divisor_zero   = (i_second_source_data == 32'h0000_0000);
  assign div_start      = exec_ok && unsigned_divide_op && !divisor_zero;
  assign div_zero_write = exec_ok && unsigned_divide_op && divisor_zero && !i_div_zero_trap_en;
  assign div_zero_trap  = exec_ok && unsigned_divide_op && divisor_zero && i_div_zero_trap_en;
  assign imm_write      = exec_ok && (packed_op || unsigned_field_extract_op);
  assign flags_write    = exec_ok && add_sub_exchange_op;

  // ----------------------------------------------------------------
  // iterative divider, one quotient bit a cycle
  // ----------------------------------------------------------------
  logic [31:0] div_rem_q;
  logic [31:0] div_quo_q;
  logic [31:0] div_den_q;
  logic [3:0]  div_dest_q;
  logic [5:0]  div_cnt_q;
  logic [32:0] div_trial;
  logic [32:0] div_sub;
  logic        div_bit;
  logic [31:0] div_rem_d;
  logic [31:0] div_quo_d;
  logic        div_finish;
  logic        dividing;

  assign dividing   = (state_q == usimd_pkg::ST_DIVIDE);
  assign div_trial  = {div_rem_q, div_quo_q[31]};
  assign div_sub    = div_trial - {1'b0, div_den_q};
  assign div_bit    = !div_sub[32];
  assign div_rem_d  = div_start ? 32'h0000_0000 : (div_bit ? div_sub[31:0] : div_trial[31:0]);
  assign div_quo_d  = div_start ? i_first_source_data : {div_quo_q[30:0], div_bit};
  assign div_finish = dividing && (div_cnt_q == usimd_pkg::DIV_LAST);
  assign state_d    = div_start ? usimd_pkg::ST_DIVIDE :
                      div_finish ? usimd_pkg::ST_IDLE : state_q;

  // operands are captured at issue so the register file may move on
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state_q    <= usimd_pkg::ST_IDLE;
      div_cnt_q  <= 6'h00;
      div_rem_q  <= 32'h0000_0000;
      div_quo_q  <= 32'h0000_0000;
      div_den_q  <= 32'h0000_0000;
      div_dest_q <= 4'h0;
    end else begin
      state_q    <= state_d;
      div_cnt_q  <= div_start ? 6'h00 : div_cnt_q + 6'h01;
      div_rem_q  <= div_rem_d;
      div_quo_q  <= div_quo_d;
      div_den_q  <= div_start ? i_second_source_data : div_den_q;
      div_dest_q <= div_start ? dest_field : div_dest_q;
    end
  end

  // ----------------------------------------------------------------
  // registered results
  // ----------------------------------------------------------------
  logic        wr_en_d;
  logic [3:0]  wr_index_d;
  logic [31:0] wr_data_d;
  logic        done_d;

  assign wr_en_d    = imm_write || div_zero_write || div_finish;
  assign wr_index_d = div_finish ? div_dest_q : dest_field;
  assign wr_data_d  = div_finish ? div_quo_d : (div_zero_write ? 32'h0000_0000 : alu_result);
  assign done_d     = (issue && recognized && !div_start) || div_finish;

  // outputs are one-cycle pulses with data held alongside
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_reg_wr_en              <= 1'b0;
      o_reg_wr_index           <= 4'h0;
      o_reg_wr_data            <= 32'h0000_0000;
      o_lane_carry_flags_wr_en <= 1'b0;
      o_lane_carry_flags       <= 4'h0;
      o_done                   <= 1'b0;
      o_undef_exc              <= 1'b0;
      o_unpredictable          <= 1'b0;
      o_div_zero_fault         <= 1'b0;
    end else begin
      o_reg_wr_en              <= wr_en_d;
      o_reg_wr_index           <= wr_index_d;
      o_reg_wr_data            <= wr_data_d;
      o_lane_carry_flags_wr_en <= flags_write;
      o_lane_carry_flags       <= carry_flags;
      o_done                   <= done_d;
      o_undef_exc              <= issue && undef_now;
      o_unpredictable          <= issue && recognized && unpred_now;
      o_div_zero_fault         <= div_zero_trap;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  a_exchange_flags_set: assert property (flags_write |=> o_lane_carry_flags_wr_en
    && o_lane_carry_flags == $past(carry_flags) && o_reg_wr_data == $past(alu_result))
    else $error("exchange op did not write result and carries");
  a_packed_absent_undef: assert property (issue && packed_op && !i_dsp_present
    |=> o_undef_exc && !o_reg_wr_en) else $error("packed op without extension not undefined");
  a_forbidden_reg_flag: assert property (issue && three_reg_op && reg_forbidden(dest_field)
    |=> o_unpredictable) else $error("register 13 or 15 destination not flagged");
  a_extract_no_main: assert property (issue && unsigned_field_extract_op && !i_main_present
    |=> o_undef_exc) else $error("extract without main extension not undefined");
  a_extract_over_undef: assert property (issue && unsigned_field_extract_op && field_over
    |=> o_undef_exc && !o_reg_wr_en) else $error("extract beyond bit 31 not undefined");
  a_undef_op_trap: assert property (issue && permanent_undefined_op
    |=> o_undef_exc && o_done && !o_reg_wr_en) else $error("permanent undefined did not trap");
  a_divide_latency: assert property (div_start |-> ##33 (o_reg_wr_en && o_done)
    ) else $error("divide result not written after 33 cycles");
  a_divide_no_flags: assert property (issue && unsigned_divide_op
    |=> !o_lane_carry_flags_wr_en [*8]) else $error("divide changed carry flags");
  a_halving_half_lanes: assert property (exec_ok && halving_add_halfwords_op
    |=> o_reg_wr_data == $past({psum_hi[16:1], psum_lo[16:1]})) else $error("halving halfword sum wrong");
  a_zero_divisor_result: assert property (div_zero_write
    |=> o_reg_wr_en && o_reg_wr_data == 32'h0000_0000) else $error("zero divisor did not write zero");
  a_cond_fail_quiet: assert property (issue && !i_cond_pass
    |=> !o_reg_wr_en && !o_lane_carry_flags_wr_en) else $error("failed condition wrote state");

  c_exchange_run: cover property (flags_write);
  c_divide_run: cover property (div_start ##33 o_done);
  c_extract_run: cover property (imm_write && unsigned_field_extract_op);
  c_undef_run: cover property (issue && permanent_undefined_op);

endmodule

// [shared/usimd_pkg.sv]
// package for the unsigned packed, field extract and divide execute block
// assumes 32-bit words, the first halfword of a long form in bits 31:16
package usimd_pkg;

  // ----------------------------------------------------------------
  // widths and register numbers
  // ----------------------------------------------------------------
  localparam int          WORD_W       = 32;
  localparam int          HALF_W       = 16;
  localparam int          BYTE_W       = 8;
  localparam int          REG_IDX_W    = 4;
  localparam int          DIV_STEPS    = 32;
  localparam logic [3:0]  REG_STACK    = 4'hD;   // register 13
  localparam logic [3:0]  REG_COUNTER  = 4'hF;   // register 15
  localparam logic [5:0]  DIV_LAST     = 6'h1F;
  localparam logic [4:0]  FIELD_TOP    = 5'h1F;

  // ----------------------------------------------------------------
  // field positions within the halfwords
  // ----------------------------------------------------------------
  localparam int          OPC_HI_LSB   = 4;      // first halfword opcode bits 15:4
  localparam int          NIB_HI_LSB   = 12;     // top nibble of a halfword
  localparam int          SUBOP_LSB    = 4;      // second halfword bits 7:4
  localparam int          LSB_HIGH_POS = 12;
  localparam int          LSB_LOW_POS  = 6;
  localparam int          RD_LSB       = 8;
  localparam int          XTR_ZERO_POS = 15;     // second halfword bit forced low
  localparam int          SHORT_OP_LSB = 8;

  // ----------------------------------------------------------------
  // opcode values
  // ----------------------------------------------------------------
  localparam logic [11:0] OPC_ASX      = 12'hFAA;
  localparam logic [11:0] OPC_HADD16   = 12'hFA9;
  localparam logic [11:0] OPC_HADD8    = 12'hFA8;
  localparam logic [11:0] OPC_HSAX     = 12'hFAE;
  localparam logic [11:0] OPC_DIVIDE   = 12'hFBB;
  localparam logic [11:0] OPC_UNDEF_L  = 12'hF7F;
  localparam logic [4:0]  OPC_FIELD_A  = 5'h1E;  // first halfword bits 15:11
  localparam logic [5:0]  OPC_FIELD_B  = 6'h3C;  // first halfword bits 9:4
  localparam logic [3:0]  NIB_ONES     = 4'hF;
  localparam logic [3:0]  NIB_UNDEF_L  = 4'hA;
  localparam logic [3:0]  SUB_PLAIN    = 4'h4;
  localparam logic [3:0]  SUB_HALVING  = 4'h6;
  localparam logic [3:0]  SUB_DIVIDE   = 4'hF;
  localparam logic [7:0]  OPC_UNDEF_S  = 8'hDE;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    ST_IDLE   = 1'b0,
    ST_DIVIDE = 1'b1
  } exec_state_t;

endpackage

// [sim/usimd_regfile_model.sv]
// register file model standing behind the execute block
// assumes the bench preloads registers through the hierarchy
`timescale 1ns/100ps

module usimd_regfile_model (
  // clock
  input  wire logic        i_clock,
  // read ports
  input  wire logic [3:0]  i_rd_a_index,
  input  wire logic [3:0]  i_rd_b_index,
  output logic      [31:0] o_rd_a_data,
  output logic      [31:0] o_rd_b_data,
  // write port
  input  wire logic        i_wr_en,
  input  wire logic [3:0]  i_wr_index,
  input  wire logic [31:0] i_wr_data
);
  logic [31:0] regs_q [16];

  // reads answer in the same cycle, as the block samples operands once
  assign o_rd_a_data = regs_q[i_rd_a_index];
  assign o_rd_b_data = regs_q[i_rd_b_index];

  // a write lands on the edge where the pulse is seen
  always @(posedge i_clock) begin
    if (i_wr_en) begin
      regs_q[i_wr_index] <= i_wr_data;
    end
  end
endmodule

// [sim/unsigned_simd_bitfield_divide_exec_tb.sv]
// self-checking bench for the unsigned packed, extract and divide block
// assumes a register file model that answers reads in the same cycle
`timescale 1ns/100ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end

module unsigned_simd_bitfield_divide_exec_tb;
  logic        clk = 1'b0, rst = 1'b1, vld = 1'b0, shrt = 1'b0, cond = 1'b1;
  logic        dsp = 1'b1, mainx = 1'b1, trap = 1'b0, rdy_c1;
  logic        rdy, we, fwe, done, und, unp, dzf;
  logic [31:0] ins = 32'h0000_0000, da, db, wd;
  logic [3:0]  ia, ib, wi, fl;
  int          miscompares = 0, total_checks = 0, lat;

  // --------------------------------------------------------------
  // block and its register file
  // --------------------------------------------------------------
  unsigned_simd_exec dut_u (.i_clock(clk), .i_sys_rst(rst), .i_instr_valid(vld), .i_instr(ins),
    .i_instr_short(shrt), .i_cond_pass(cond), .i_dsp_present(dsp), .i_main_present(mainx),
    .i_div_zero_trap_en(trap), .o_ready(rdy), .o_first_source_index(ia), .o_second_source_index(ib),
    .i_first_source_data(da), .i_second_source_data(db), .o_reg_wr_en(we), .o_reg_wr_index(wi),
    .o_reg_wr_data(wd), .o_lane_carry_flags_wr_en(fwe), .o_lane_carry_flags(fl), .o_done(done),
    .o_undef_exc(und), .o_unpredictable(unp), .o_div_zero_fault(dzf));
  usimd_regfile_model rf_u (.i_clock(clk), .i_rd_a_index(ia), .i_rd_b_index(ib), .o_rd_a_data(da),
    .o_rd_b_data(db), .i_wr_en(we), .i_wr_index(wi), .i_wr_data(wd));

  // free-running 50 MHz clock
  always #10 clk = ~clk;

  // encoders for the three-register and extract long forms
  function automatic logic [31:0] op3(logic [11:0] o, logic [3:0] s, logic [3:0] n, logic [3:0] d,
                                      logic [3:0] m);
    return {o, n, 4'hF, d, s, m};
  endfunction
  function automatic logic [31:0] bfx(logic [4:0] lsb, logic [4:0] wm1);
    return {16'hF3C5, 1'b0, lsb[4:2], 4'h6, lsb[1:0], 1'b0, wm1};
  endfunction

  // offer one word, drop it after the taking edge, wait bounded for done
  task automatic exec(input logic [31:0] w, input logic s);
    @(negedge clk);
    ins = w;
    shrt = s;
    vld = 1'b1;
    @(negedge clk);
    vld = 1'b0;
    rdy_c1 = rdy;
    lat = 0;
    while (done !== 1'b1 && lat < 40) begin
      @(negedge clk);
      lat++;
    end
  endtask

  // judge the outcome cycle
  task automatic res(input logic w, input logic [31:0] d, input logic u);
    `CHK("done", 1'b1, done)
    `CHK("write enable", w, we)
    `CHK("undefined", u, und)
    `CHK("unpredictable", 1'b0, unp)
    if (w) `CHK("write data", d, wd)
    if (w) `CHK("write index", 4'h6, wi)
  endtask

  task automatic t_packed;
    exec(op3(usimd_pkg::OPC_HADD16, usimd_pkg::SUB_HALVING, 4'h1, 4'h6, 4'h2), 1'b0);
    res(1'b1, 32'hFFFF_0002, 1'b0);
    exec(op3(usimd_pkg::OPC_HADD8, usimd_pkg::SUB_HALVING, 4'hA, 4'h6, 4'hB), 1'b0);
    res(1'b1, 32'h8080_0204, 1'b0);
    exec(op3(usimd_pkg::OPC_ASX, usimd_pkg::SUB_HALVING, 4'h3, 4'h6, 4'h4), 1'b0);
    res(1'b1, 32'h0006_FFFE, 1'b0);
    exec(op3(usimd_pkg::OPC_HSAX, usimd_pkg::SUB_HALVING, 4'h3, 4'h6, 4'h4), 1'b0);
    res(1'b1, 32'hFFFE_0004, 1'b0);
    exec(op3(usimd_pkg::OPC_ASX, usimd_pkg::SUB_PLAIN, 4'h1, 4'h6, 4'h2), 1'b0);
    res(1'b1, 32'h0002_0002, 1'b0);
    `CHK("flag write", 1'b1, fwe)
    `CHK("carry flags", 4'h3, fl)
    exec(op3(usimd_pkg::OPC_HADD16, usimd_pkg::SUB_HALVING, 4'h1, 4'hD, 4'h2), 1'b0);
    `CHK("unpredictable", 1'b1, unp)
  endtask

  // every packed op refused without the signal-processing extension
  task automatic t_no_dsp;
    logic [11:0] o [5] = '{usimd_pkg::OPC_ASX, usimd_pkg::OPC_ASX, usimd_pkg::OPC_HADD16,
                           usimd_pkg::OPC_HADD8, usimd_pkg::OPC_HSAX};
    dsp = 1'b0;
    for (int i = 0; i < 5; i++) begin
      exec(op3(o[i], i == 0 ? usimd_pkg::SUB_PLAIN : usimd_pkg::SUB_HALVING, 4'h1, 4'h6, 4'h2), 1'b0);
      res(1'b0, 32'h0000_0000, 1'b1);
    end
    dsp = 1'b1;
  endtask

  task automatic t_extract;
    exec(bfx(5'h04, 5'h07), 1'b0);
    res(1'b1, 32'h0000_0067, 1'b0);
    exec(bfx(5'h00, 5'h1F), 1'b0);
    res(1'b1, 32'h9234_5678, 1'b0);
    exec(bfx(5'h1F, 5'h00), 1'b0);
    res(1'b1, 32'h0000_0001, 1'b0);
    exec(bfx(5'h04, 5'h1C), 1'b0);
    res(1'b0, 32'h0000_0000, 1'b1);
    mainx = 1'b0;
    exec(bfx(5'h04, 5'h07), 1'b0);
    res(1'b0, 32'h0000_0000, 1'b1);
    mainx = 1'b1;
    // source field moved to register 15
    exec(bfx(5'h04, 5'h07) | 32'h000A_0000, 1'b0);
    `CHK("unpredictable", 1'b1, unp)
  endtask

  task automatic t_divide;
    exec(op3(usimd_pkg::OPC_DIVIDE, usimd_pkg::SUB_DIVIDE, 4'hC, 4'h6, 4'hE), 1'b0);
    res(1'b1, 32'h0000_000E, 1'b0);
    `CHK("ready while dividing", 1'b0, rdy_c1)
    `CHK("divide latency", 32'h0000_0020, lat)
    `CHK("flag write", 1'b0, fwe)
    exec(op3(usimd_pkg::OPC_DIVIDE, usimd_pkg::SUB_DIVIDE, 4'hC, 4'h6, 4'h9), 1'b0);
    res(1'b1, 32'h0000_0000, 1'b0);
    `CHK("divide fault", 1'b0, dzf)
    trap = 1'b1;
    exec(op3(usimd_pkg::OPC_DIVIDE, usimd_pkg::SUB_DIVIDE, 4'hC, 4'h6, 4'h9), 1'b0);
    res(1'b0, 32'h0000_0000, 1'b0);
    `CHK("divide fault", 1'b1, dzf)
    trap = 1'b0;
  endtask

  // payload values differ, outcome must not
  task automatic t_undef_cond;
    exec({16'h0000, usimd_pkg::OPC_UNDEF_S, 8'hA5}, 1'b1);
    res(1'b0, 32'h0000_0000, 1'b1);
    exec({usimd_pkg::OPC_UNDEF_L, 4'h9, usimd_pkg::NIB_UNDEF_L, 12'h5C3}, 1'b0);
    res(1'b0, 32'h0000_0000, 1'b1);
    // a flag-writing op, so a missed gate would show on both enables
    cond = 1'b0;
    exec(op3(usimd_pkg::OPC_ASX, usimd_pkg::SUB_PLAIN, 4'h1, 4'h6, 4'h2), 1'b0);
    res(1'b0, 32'h0000_0000, 1'b0);
    `CHK("flag write", 1'b0, fwe)
    cond = 1'b1;
  endtask

  task automatic print_verdict;
    if (miscompares == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    print_verdict();
  end

  // preload operands, reset, then run every scenario
  initial begin
    rf_u.regs_q[1] = 32'hFFFF_0001;
    rf_u.regs_q[2] = 32'hFFFF_0003;
    rf_u.regs_q[3] = 32'h0004_0002;
    rf_u.regs_q[4] = 32'h0006_0008;
    rf_u.regs_q[5] = 32'h9234_5678;
    rf_u.regs_q[9] = 32'h0000_0000;
    rf_u.regs_q[10] = 32'hFF10_0203;
    rf_u.regs_q[11] = 32'h01F0_0305;
    rf_u.regs_q[12] = 32'h0000_0064;
    rf_u.regs_q[14] = 32'h0000_0007;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_packed();
    t_no_dsp();
    t_extract();
    t_divide();
    t_undef_cond();
    print_verdict();
  end
endmodule
